//--- logic/spi_gpio_pkg.sv
`default_nettype none
package spi_gpio_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // System clock rate in hertz.
  localparam int CLK_HZ = 100_000_000;
  // Fastest serial clock rate in hertz; slower codes halve it.
  localparam int SCK_MAX_HZ = 4_096_000;
  // Half period of the fastest serial clock, rounded down to cycles.
  localparam int SCK_HALF_MIN_CYC = CLK_HZ / (2 * SCK_MAX_HZ);
  // Transfer watchdog time in microseconds.
  localparam int TIMEOUT_US = 10_000;
  // Watchdog time as system clock cycles.
  localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 12;
  localparam int CS_COUNT = 5;
  localparam int SI_COUNT = 4;
  localparam int BOOT_PIN = 11;
  localparam int RATE_BITS = 3;
  localparam int REG_W = 24;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_CMD = 8'h11;
  localparam logic [7:0] ADDR_DATA = 8'h12;
  localparam logic [7:0] ADDR_PIN_A = 8'h20;
  localparam logic [7:0] ADDR_PIN_B = 8'h21;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  // The serial master control register, most significant bit first.
  typedef struct packed {
    logic wiredOr;
    logic clockPhaseBit;
    logic clockPolarityBit;
    logic [2:0] clockRateSelect;
    logic timeoutFlag;
    logic writeCollisionFlag;
    logic transferBusyFlag;
    logic transferRequest;
    logic [2:0] byteCount;
    logic [1:0] receiveChannelSelect;
    logic [3:0] inputEnableBits;
    logic [4:0] csEnable;
  } ctrl_s;

  // Pin configuration A: pull-up enables above directions.
  typedef struct packed {
    logic [11:0] pullupEnable;
    logic [11:0] pinDirection;
  } pin_cfg_s;

  localparam int PIN_DIR_LSB = 0;
  localparam int PIN_PULL_LSB = 12;
  localparam logic [23:0] CTRL_RESET = 24'h00_0000;
  localparam logic [23:0] PIN_A_RESET = 24'hFF_F000;
  localparam logic [11:0] PIN_B_RESET = 12'h000;

  // Transfer sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN, ST_HOLD} xfer_state_e;

endpackage
`default_nettype wire

//--- logic/half_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Produces one tick per serial clock half period while run is high.
module half_period_timer
  import spi_gpio_pkg::*;
#(
  parameter int HALF_MIN = SCK_HALF_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [2:0] rate,
  output logic tick
);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The longest half period must fit the counter below.
  if (HALF_MIN < 1 || HALF_MIN * 128 > 65535) begin : badHalf
    $error("half period out of range");
  end

  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [15:0] limit;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Code seven is the fastest rate; each step down doubles the half.
  always_comb begin
    limit = 16'(HALF_MIN) << (3'd7 - rate);
    count_nxt = count_r;
    tick_nxt = 1'b0;
    if (!run) begin
      count_nxt = 16'h0000;
    end else if (count_r == limit - 16'h0001) begin
      count_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end else begin
      count_nxt = count_r + 16'h0001;
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule
`default_nettype wire

//--- logic/spi_master_with_gpio_pins.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_with_gpio_pins
  import spi_gpio_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [23:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [23:0] regRdata,
  output logic masterSerialClock,
  output logic masterSerialClockOe,
  output logic serialOut,
  output logic serialOutOe,
  input wire logic [3:0] serialIn,
  input wire logic bootMemorySelectN,
  input wire logic [11:0] pinIn,
  output logic [11:0] pinOut,
  output logic [11:0] pinOe,
  output logic [11:0] pinPullEn
);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The watchdog must last at least 16 system clock cycles.
  if (TIMEOUT_CYCLES < 16 || TIMEOUT_CYCLES > 32'h7FFF_FFFF) begin : badTo
    $error("timeout count out of range");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [3:0] siMeta_r;  // First synchroniser stage, serial inputs.
  logic [3:0] siSync_r;  // Second stage, safe to read.
  logic [11:0] pinMeta_r;  // First synchroniser stage, pins.
  logic [11:0] pinSync_r;  // Second stage, the live pin level.
  ctrl_s ctrl_r;  // Control register.
  ctrl_s ctrl_nxt;
  logic [15:0] cmd_r;  // Command and address holding register.
  logic [15:0] cmd_nxt;
  logic [23:0] data_r;  // Transfer data holding register.
  logic [23:0] data_nxt;
  pin_cfg_s pinCfg_r;  // Pin configuration A.
  pin_cfg_s pinCfg_nxt;
  logic [11:0] pinVal_r;  // Written pin output values.
  logic [11:0] pinVal_nxt;
  logic [23:0] rdata_r;  // Read data, valid one cycle after the strobe.
  logic [23:0] rdata_nxt;
  xfer_state_e state_r;
  xfer_state_e state_nxt;
  logic [3:0] edge_r;  // Serial clock edge within the byte.
  logic [3:0] edge_nxt;
  logic [2:0] byteIdx_r;  // Byte of the transfer being shifted.
  logic [2:0] byteIdx_nxt;
  logic [7:0] shift_r;  // The one bidirectional shift register.
  logic [7:0] shift_nxt;
  logic sck_r;
  logic sck_nxt;
  logic mosi_r;
  logic mosi_nxt;
  logic csActive_r;  // High while the selected slaves are addressed.
  logic csActive_nxt;
  logic [31:0] toCnt_r;  // Watchdog cycle count.
  logic [31:0] toCnt_nxt;
  logic tick;  // One pulse per serial clock half period.
  logic [11:0] pinOut_r;
  logic [11:0] pinOut_nxt;
  logic [11:0] pinOe_r;
  logic [11:0] pinOe_nxt;
  logic [11:0] pinPull_r;
  logic [11:0] pinPull_nxt;
  logic sckOe_r;
  logic sckOe_nxt;
  logic mosiOe_r;
  logic mosiOe_nxt;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Byte k of the outgoing stream: command high, command low, then
  // the low-aligned data bytes, most significant first.
  function automatic logic [7:0] byteOf(input logic [2:0] k,
                                        input logic [2:0] last,
                                        input logic [15:0] cmd,
                                        input logic [23:0] dat);
    logic [2:0] d;
    d = last - k;
    if (k == 3'd0) begin
      byteOf = cmd[15:8];
    end else if (k == 3'd1) begin
      byteOf = cmd[7:0];
    end else begin
      byteOf = dat[8*d +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Serial inputs and pins come from outside, so two stages each.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      siMeta_r <= 4'h0;
      siSync_r <= 4'h0;
      pinMeta_r <= 12'h000;
      pinSync_r <= 12'h000;
    end else begin
      siMeta_r <= serialIn;
      siSync_r <= siMeta_r;
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // Serial clock rate timer
  // ---------------------------------------------------------------
  // Runs only while a transfer is active, so every transfer starts
  // with a full half period of setup.
  half_period_timer #(
    .HALF_MIN(SCK_HALF_MIN_CYC)
  ) rateTimer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(state_r != ST_IDLE),
    .rate(ctrl_r.clockRateSelect),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Registers and transfer sequencer
  // ---------------------------------------------------------------
  // Bus writes are applied first and hardware events afterwards, so a
  // flag set by hardware wins over a clear in the same cycle.
  always_comb begin
    logic isSample;
    logic [7:0] shifted;
    logic [7:0] nextByte;
    logic rxBit;
    logic [2:0] dIdx;
    ctrl_s wr;
    isSample = 1'b0;
    shifted = 8'h00;
    nextByte = 8'h00;
    rxBit = 1'b0;
    dIdx = 3'd0;
    wr = ctrl_s'(regWdata);
    ctrl_nxt = ctrl_r;
    cmd_nxt = cmd_r;
    data_nxt = data_r;
    pinCfg_nxt = pinCfg_r;
    pinVal_nxt = pinVal_r;
    state_nxt = state_r;
    edge_nxt = edge_r;
    byteIdx_nxt = byteIdx_r;
    shift_nxt = shift_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    csActive_nxt = csActive_r;
    toCnt_nxt = toCnt_r;

    // Software writes.
    if (regWrite) begin
      unique case (regAddr)
        ADDR_CTRL: begin
          // Writing zero to a flag clears it; one leaves it alone.
          ctrl_nxt.timeoutFlag = ctrl_r.timeoutFlag & wr.timeoutFlag;
          ctrl_nxt.writeCollisionFlag =
              ctrl_r.writeCollisionFlag & wr.writeCollisionFlag;
          if (state_r == ST_IDLE) begin
            // Configuration is frozen while a transfer runs.
            ctrl_nxt.wiredOr = wr.wiredOr;
            ctrl_nxt.clockPhaseBit = wr.clockPhaseBit;
            ctrl_nxt.clockPolarityBit = wr.clockPolarityBit;
            ctrl_nxt.clockRateSelect = wr.clockRateSelect;
            ctrl_nxt.byteCount = wr.byteCount;
            ctrl_nxt.receiveChannelSelect = wr.receiveChannelSelect;
            ctrl_nxt.inputEnableBits = wr.inputEnableBits;
            ctrl_nxt.csEnable = wr.csEnable;
            ctrl_nxt.transferRequest = wr.transferRequest;
          end else if (wr.transferRequest) begin
            ctrl_nxt.writeCollisionFlag = 1'b1;
          end
        end
        ADDR_CMD: cmd_nxt = regWdata[15:0];
        ADDR_DATA: data_nxt = regWdata;
        ADDR_PIN_A: pinCfg_nxt = pin_cfg_s'(regWdata);
        ADDR_PIN_B: pinVal_nxt = regWdata[11:0];
        default: ;
      endcase
    end

    // Receive bit from the one enabled, selected input.
    rxBit = siSync_r[ctrl_r.receiveChannelSelect] &
            ctrl_r.inputEnableBits[ctrl_r.receiveChannelSelect];

    // Transfer sequencer.
    unique case (state_r)
      ST_IDLE: begin
        sck_nxt = ctrl_r.clockPolarityBit;
        csActive_nxt = 1'b0;
        toCnt_nxt = 32'h0000_0000;
        if (ctrl_r.transferRequest) begin
          nextByte = byteOf(3'd0, ctrl_r.byteCount, cmd_r, data_r);
          shift_nxt = nextByte;
          mosi_nxt = nextByte[7];
          edge_nxt = 4'h0;
          byteIdx_nxt = 3'd0;
          csActive_nxt = 1'b1;
          ctrl_nxt.transferBusyFlag = 1'b1;
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Two half periods between select and first clock edge: this one and the first in run.
        if (tick) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tick) begin
          sck_nxt = ~sck_r;
          // Phase zero samples on leading edges, phase one on trailing.
          isSample = (edge_r[0] == ctrl_r.clockPhaseBit);
          shifted = isSample ? {shift_r[6:0], rxBit} : shift_r;
          if (edge_r == 4'hF) begin
            // Received bytes land low-aligned in the data register.
            if (byteIdx_r >= 3'd2) begin
              dIdx = ctrl_r.byteCount - byteIdx_r;
              data_nxt[8*dIdx +: 8] = shifted;
            end
            edge_nxt = 4'h0;
            if (byteIdx_r == ctrl_r.byteCount) begin
              state_nxt = ST_HOLD;
            end else begin
              byteIdx_nxt = byteIdx_r + 3'd1;
              nextByte = byteOf(byteIdx_nxt, ctrl_r.byteCount,
                                cmd_r, data_r);
              shift_nxt = nextByte;
              if (!ctrl_r.clockPhaseBit) begin
                mosi_nxt = nextByte[7];
              end
            end
          end else begin
            shift_nxt = shifted;
            if (!isSample) begin
              mosi_nxt = shift_r[7];
            end
            edge_nxt = edge_r + 4'h1;
          end
        end
      end
      ST_HOLD: begin
        // Last half period keeps the select low before release.
        if (tick) begin
          state_nxt = ST_IDLE;
          csActive_nxt = 1'b0;
          ctrl_nxt.transferRequest = 1'b0;
          ctrl_nxt.transferBusyFlag = 1'b0;
        end
      end
    endcase

    // Watchdog: a stuck transfer is abandoned and flagged.
    if (state_r != ST_IDLE) begin
      toCnt_nxt = toCnt_r + 32'h0000_0001;
      if (toCnt_r == 32'(TIMEOUT_CYCLES - 1)) begin
        state_nxt = ST_IDLE;
        csActive_nxt = 1'b0;
        sck_nxt = ctrl_r.clockPolarityBit;
        ctrl_nxt.timeoutFlag = 1'b1;
        ctrl_nxt.transferRequest = 1'b0;
        ctrl_nxt.transferBusyFlag = 1'b0;
      end
    end

    // Read data for the cycle after the strobe, zero otherwise.
    rdata_nxt = 24'h00_0000;
    if (regRead) begin
      unique case (regAddr)
        ADDR_CTRL: rdata_nxt = ctrl_r;
        ADDR_CMD: rdata_nxt = {8'h00, cmd_r};
        ADDR_DATA: rdata_nxt = data_r;
        ADDR_PIN_A: rdata_nxt = pinCfg_r;
        ADDR_PIN_B: rdata_nxt = {12'h000, pinSync_r};
        default: rdata_nxt = 24'h00_0000;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r <= ctrl_s'(CTRL_RESET);
      cmd_r <= 16'h0000;
      data_r <= 24'h00_0000;
      pinCfg_r <= pin_cfg_s'(PIN_A_RESET);
      pinVal_r <= PIN_B_RESET;
      rdata_r <= 24'h00_0000;
      state_r <= ST_IDLE;
      edge_r <= 4'h0;
      byteIdx_r <= 3'd0;
      shift_r <= 8'h00;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      csActive_r <= 1'b0;
      toCnt_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      cmd_r <= cmd_nxt;
      data_r <= data_nxt;
      pinCfg_r <= pinCfg_nxt;
      pinVal_r <= pinVal_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      edge_r <= edge_nxt;
      byteIdx_r <= byteIdx_nxt;
      shift_r <= shift_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      csActive_r <= csActive_nxt;
      toCnt_r <= toCnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Pads 0 to 4 and 11 are each a plain pin or, when its written value is one,
  // a chip select: the select is gated by the pin's own data bit, so
  // a pin written low can never carry a select.
  always_comb begin
    logic selN;
    logic val;
    selN = 1'b1;
    val = 1'b0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      selN = 1'b1;
      if (i < CS_COUNT) begin
        selN = ~(csActive_r & ctrl_r.csEnable[i]);
      end else if (i == BOOT_PIN) begin
        selN = bootMemorySelectN;
      end
      val = pinVal_r[i] & selN;
      pinOut_nxt[i] = val;
      pinOe_nxt[i] = pinCfg_r.pinDirection[i];
      // Driving low switches the pull-up off.
      pinPull_nxt[i] = pinCfg_r.pullupEnable[i] &
                       ~(pinCfg_r.pinDirection[i] & ~val);
    end
    // Wired-or drives only the low level and lets the pull-up rise.
    sckOe_nxt = ~ctrl_r.wiredOr | ~sck_r;
    mosiOe_nxt = ~ctrl_r.wiredOr | ~mosi_r;
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pinOut_r <= 12'h000;
      pinOe_r <= 12'h000;
      pinPull_r <= 12'hFFF;
      sckOe_r <= 1'b1;
      mosiOe_r <= 1'b1;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
      pinPull_r <= pinPull_nxt;
      sckOe_r <= sckOe_nxt;
      mosiOe_r <= mosiOe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regRdata = rdata_r;
  assign masterSerialClock = sck_r;
  assign masterSerialClockOe = sckOe_r;
  assign serialOut = mosi_r;
  assign serialOutOe = mosiOe_r;
  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign pinPullEn = pinPull_r;

endmodule
`default_nettype wire

//--- bench/spi_gpio_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the block from its ports only; helper logic is not needed.
module spi_gpio_monitor
  import spi_gpio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [23:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [23:0] regRdata,
  input wire logic masterSerialClock,
  input wire logic bootMemorySelectN,
  input wire logic [11:0] pinIn,
  input wire logic [11:0] pinOut,
  input wire logic [11:0] pinOe,
  input wire logic [11:0] pinPullEn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 0)
    else $error("read data not idle");
  AST_PULL_OFF_LOW: assert property ((pinOe & ~pinOut & pinPullEn) == 0)
    else $error("pull-up on a pin driven low");
  // No clock edge follows another within eight cycles of it.
  AST_SCK_HALF: assert property ($changed(masterSerialClock) |=>
    $stable(masterSerialClock) [*8]) else $error("serial clock too fast");
  AST_SEL_HOLD: assert property ($fell(pinOut[0]) |=> !pinOut[0] [*8])
    else $error("select released early");
  AST_BOOT_SEL: assert property (!bootMemorySelectN [*3] |-> !pinOut[11])
    else $error("boot select not gated onto pin");
  AST_LIVE_READ: assert property ($stable(pinIn) [*4] ##0
    (regRead && regAddr == ADDR_PIN_B) |=> regRdata[11:0] == $past(pinIn))
    else $error("pin read not live");
  AST_DIR_WRITE: assert property (regWrite && regAddr == ADDR_PIN_A
    ##1 !regWrite [*2] |-> pinOe == $past(regWdata[11:0], 2))
    else $error("direction not applied");
  AST_REQ_SELECT: assert property (regWrite && regAddr == ADDR_CTRL
    && regWdata[14] && regWdata[0] && pinOe[0] && (&pinOut[4:0])
    |-> ##[1:4] !pinOut[0]) else $error("request did not start");

  cover property ($fell(pinOut[0]));
  cover property (regRead && regAddr == ADDR_PIN_B);
  cover property ($changed(masterSerialClock));
endmodule
`default_nettype wire

//--- bench/serial_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial slave: shifts txBits out MSB first and records what it hears.
module serial_slave_model (
  input wire logic sys_clk,
  input wire logic selN,
  input wire logic sck,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [39:0] txBits,
  output logic miso,
  output logic [39:0] rxBits
);
  int idx = 0;
  logic junk = 1'b0;
  // A released line toggles, so stale data is never mistaken for a bit.
  always @(posedge sys_clk) junk <= ~junk;
  // Phase one presents its first bit only on the leading edge.
  always @(negedge selN) begin
    idx = cpha ? -1 : 0;
    rxBits = '0;
  end
  // Sample on one edge, move to the next bit on the other.
  always @(sck) begin
    if (!selN && sck == ~(cpol ^ cpha))
      rxBits = {rxBits[38:0], mosi};
    else if (!selN)
      idx = idx + 1;
  end
  assign miso = (selN || idx < 0 || idx > 39) ? junk : txBits[39 - idx];
endmodule
`default_nettype wire

//--- bench/spi_master_with_gpio_pins_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_with_gpio_pins_test;
  import spi_gpio_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [23:0] regWdata = 24'h00_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic bootMemorySelectN = 1'b1;
  logic [23:0] regRdata, rd;
  logic masterSerialClock, serialOut, miso, sckSeen, sckOe, soOe;
  logic [3:0] serialIn;
  logic [11:0] pinOut, pinOe, pinPullEn, pinLvl;
  logic [11:0] ext = 12'h000;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [1:0] chan = 2'd0;
  logic [39:0] txBits = '0;
  logic [39:0] rxBits;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int halfCnt = 0;
  int expHalf = 12;

  always #5 sys_clk = ~sys_clk;
  // Pin level: our drive, else the pull-up, else the outside world.
  assign pinLvl = (pinOe & pinOut) | (~pinOe & (pinPullEn | ext));
  // Unchosen inputs carry the inverse, so a wrong pick shows.
  assign serialIn = {4{~miso}} ^ (4'b0001 << chan);

  spi_master_with_gpio_pins #(.TIMEOUT_CYCLES(5000))
    i_spi_master_with_gpio_pins (.sys_clk, .resetn, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .masterSerialClock,
    .masterSerialClockOe(sckOe), .serialOut, .serialOutOe(soOe), .serialIn,
    .bootMemorySelectN, .pinIn(pinLvl), .pinOut, .pinOe, .pinPullEn);
  serial_slave_model i_serial_slave_model (.sys_clk, .selN(pinLvl[0]),
    .sck(masterSerialClock), .mosi(serialOut), .cpol, .cpha, .txBits,
    .miso, .rxBits);

  task automatic chk(input string nm, input logic [39:0] seen,
                     input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang counts as a mismatch and still reaches the report.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      summarize();
    end
  end
  // Inside a frame the serial clock moves once every half period.
  always @(posedge sys_clk) begin
    if (pinLvl[0] !== 1'b0)
      halfCnt = 0;
    else if (masterSerialClock !== sckSeen) begin
      if (halfCnt > 0) chk("half period", halfCnt, expHalf);
      halfCnt = 1;
    end else if (halfCnt > 0)
      halfCnt++;
    sckSeen = masterSerialClock;
  end

  initial begin
    int n;
    logic [2:0] rate;
    logic [15:0] cmd;
    logic [23:0] dat, exp, ctl;
    logic [11:0] dir, pul, val;
    logic [39:0] sent;
    logic [7:0] q[$];
    void'($urandom(32'h1e7c));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdr(ADDR_PIN_A);
    chk("pin config", rd, PIN_A_RESET);
    chk("pin enables", {pinOe, pinPullEn}, 24'h00_0FFF);
    rdr(ADDR_CTRL);
    chk("control", rd, CTRL_RESET);
    rdr(8'h33);
    chk("unmapped", rd, 0);
    // Random pin setups; pin 0 keeps value one for the select path.
    repeat (6) begin
      dir = 12'($urandom);
      pul = 12'($urandom);
      val = 12'($urandom) | 12'h001;
      ext <= 12'($urandom);
      wr(ADDR_PIN_A, {pul, dir});
      repeat (2) @(posedge sys_clk);
      wr(ADDR_PIN_B, {12'h000, val});
      repeat (4) @(posedge sys_clk);
      chk("pin drive", pinOe, dir);
      chk("pulls", pinPullEn & ~(dir & val), pul & ~dir);
      rdr(ADDR_PIN_B);
      chk("pin read", rd[11:0], (dir & val) | (~dir & (pul | ext)));
    end
    // All pins out high with pulls off, then the boot select gates pin 11.
    wr(ADDR_PIN_A, 24'h00_0FFF);
    repeat (2) @(posedge sys_clk);
    wr(ADDR_PIN_B, 24'h00_0FFF);
    bootMemorySelectN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdr(ADDR_PIN_B);
    chk("boot pin", rd[11:0], 12'h7FF);
    bootMemorySelectN <= 1'b1;
    // Four clock modes on four input channels, then a fifth run that times out.
    // Mode three also runs wired-or, where the drivers only pull low.
    for (int m = 0; m < 5; m++) begin
      n = (m == 4) ? 0 : 4 - m;
      {cpha, cpol} = m[1:0];
      chan = m[1:0];
      cmd = 16'($urandom);
      dat = 24'($urandom);
      txBits = {$urandom, 8'($urandom)};
      rate = (m == 4) ? 3'd0 : (m == 1) ? 3'd6 : 3'd7;
      expHalf = SCK_HALF_MIN_CYC << (7 - rate);
      ctl = {m == 3, cpha, cpol, rate, 4'h1, n[2:0], chan, 4'hF, 5'h05};
      wr(ADDR_CMD, {8'h00, cmd});
      wr(ADDR_DATA, dat);
      wr(ADDR_CTRL, ctl);
      rdr(ADDR_CTRL);
      chk("busy", rd[15:14], 2'b11);
      chk("selects", {pinLvl[2], pinLvl[1], pinLvl[0]}, 3'b010);
      chk("oe", {sckOe, soOe}, {m != 3 || !cpol, m != 3 || !cmd[15]});
      if (m == 2) wr(ADDR_CTRL, ctl);
      for (int k = 0; k < 3000 && rd[15] === 1'b1; k++) rdr(ADDR_CTRL);
      chk("status", rd[17:14], {m == 4, m == 2, 2'b00});
      if (m < 4) begin
        q = {cmd[15:8], cmd[7:0]};
        for (int i = 2; i <= n; i++) q.push_back(dat[8*(n-i) +: 8]);
        sent = '0;
        for (int i = 0; i <= n; i++) sent = {sent[31:0], q[i]};
        chk("bits sent", rxBits, sent);
        exp = dat;
        for (int i = 2; i <= n; i++) exp[8*(n-i) +: 8] = txBits[39-8*i -: 8];
        rdr(ADDR_DATA);
        chk("bits received", rd, exp);
      end
    end
    wr(ADDR_CTRL, 24'h00_0000);
    rdr(ADDR_CTRL);
    chk("flags cleared", rd[17:16], 2'b00);
    summarize();
  end
endmodule

bind spi_master_with_gpio_pins spi_gpio_monitor i_spi_gpio_monitor (
  .sys_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
  .masterSerialClock, .bootMemorySelectN, .pinIn, .pinOut, .pinOe,
  .pinPullEn);
`default_nettype wire
